// ---- bcs_mem_model.sv ----
// Memory on the far side of the bus: address-pattern data and wait stretch.
// Assumes strobes come from the sequencer; wait length set by the bench.
`timescale 1ns/10ps
module bcs_mem_model (
    input  wire logic        clock,
    input  wire logic [15:0] addr,
    input  wire logic        memory_request_strobe_b,
    input  wire logic        read_strobe_b,
    input  wire logic [1:0]  wait_len,
    output logic [7:0]       data_in,
    output logic             wait_b
);
    logic [7:0] last_q = 8'h00;
    logic [1:0] cnt_q  = 2'h0;
    logic       sel;
    assign sel = !memory_request_strobe_b && !read_strobe_b;
    // Released bus toggles so a stale byte can never pass for a match
    assign data_in = sel ? (addr[7:0] ^ addr[15:8] ^ 8'h5A) : ~last_q;
    assign wait_b = !(!read_strobe_b && cnt_q < wait_len);
    always_ff @(posedge clock) begin
        last_q <= data_in;
        cnt_q  <= read_strobe_b ? 2'h0 : (cnt_q == 2'h3 ? cnt_q : cnt_q + 2'h1);
    end
endmodule : bcs_mem_model

// ---- bcs_pkg.sv ----
// Shared constants for the bus-cycle and interrupt sequencer.
// Assumes a single 50 MHz system clock; no software-visible registers.
package bcs_pkg;

    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          MIN_T_STATES   = 3;
    localparam logic [15:0] NMI_VECTOR     = 16'h0066;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    // Serial delays counted in system clock periods
    localparam int          SER_DLY_MIN    = 5;
    localparam int          SER_DLY_MAX    = 9;
    localparam logic [3:0]  SER_DLY_CYC    = 4'h6;
    localparam int          SER_RATE_RATIO = 5;

    typedef enum logic [2:0] {
        BCS_T1 = 3'b000,
        BCS_T2 = 3'b001,
        BCS_TW = 3'b010,
        BCS_T3 = 3'b011,
        BCS_T4 = 3'b100
    } bcs_tstate_t;

    typedef enum logic [1:0] {
        BCS_CYC_FETCH = 2'b00,
        BCS_CYC_READ  = 2'b01,
        BCS_CYC_NMI   = 2'b10
    } bcs_cycle_t;

endpackage : bcs_pkg

// ---- bcs_seq_props.sv ----
// Port checker for the bus-cycle sequencer.
// Assumes clock-synchronous inputs; bound to every sequencer instance.
`timescale 1ns/10ps
module bcs_seq_props (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [15:0] addr,
    input wire logic        addr_oe,
    input wire logic        ctrl_oe,
    input wire logic        memory_request_strobe_b,
    input wire logic        read_strobe_b,
    input wire logic        refresh_strobe_b,
    input wire logic        opcode_fetch_cycle_b,
    input wire logic        wait_b,
    input wire logic        bus_float_test_mode,
    input wire logic        nmi_taken,
    input wire logic [15:0] pc,
    input wire logic        transmit_clock_in,
    input wire logic        ser_ready_mode,
    input wire logic        ser_tx_event,
    input wire logic        ser_wait_ready_b,
    input wire logic        ser_irq_b
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    fetch_len_a: assert property (
        $fell(opcode_fetch_cycle_b) |=> !opcode_fetch_cycle_b)
        else $error("fetch indicator shorter than two states");
    fetch_strobe_a: assert property (
        $fell(opcode_fetch_cycle_b) |=> !memory_request_strobe_b && !read_strobe_b)
        else $error("strobes not active in second fetch state");
    refresh_run_a: assert property (
        $rose(opcode_fetch_cycle_b) |-> !refresh_strobe_b[*2] ##1 refresh_strobe_b)
        else $error("refresh not in exactly two states after fetch");
    refresh_addr_a: assert property (
        !refresh_strobe_b |-> addr[15:7] == 9'h000 && read_strobe_b)
        else $error("refresh with read strobe or wide address");
    float_oe_a: assert property (
        addr_oe == !bus_float_test_mode && ctrl_oe == !bus_float_test_mode)
        else $error("bus enables disagree with float mode");
    wait_hold_a: assert property (
        $fell(opcode_fetch_cycle_b) ##1 (!wait_b)[*2] |-> !opcode_fetch_cycle_b)
        else $error("wait input ignored in fetch");
    nmi_vec_a: assert property (
        nmi_taken |-> ##[1:8] pc == bcs_pkg::NMI_VECTOR)
        else $error("no restart at interrupt vector");
    ser_rdy_a: assert property (
        ser_ready_mode && ser_wait_ready_b && $fell(transmit_clock_in)
        |=> ser_wait_ready_b[*3] ##[1:5] !ser_wait_ready_b)
        else $error("ready output delay out of range");
    ser_irq_a: assert property (
        ser_tx_event && ser_irq_b && $fell(transmit_clock_in)
        |=> ser_irq_b[*3] ##[1:5] !ser_irq_b)
        else $error("serial interrupt delay out of range");

    nmi_seen_c: cover property (nmi_taken);
    wait_seen_c: cover property (!wait_b && !opcode_fetch_cycle_b);
    ser_irq_c: cover property ($fell(ser_irq_b));
endmodule : bcs_seq_props

bind bcs_sequencer bcs_seq_props i_props (
    .clock, .rst_b, .addr, .addr_oe, .ctrl_oe, .memory_request_strobe_b, .read_strobe_b,
    .refresh_strobe_b, .opcode_fetch_cycle_b, .wait_b, .bus_float_test_mode, .nmi_taken,
    .pc, .transmit_clock_in, .ser_ready_mode, .ser_tx_event, .ser_wait_ready_b, .ser_irq_b);

// ---- bcs_sequencer.sv ----
// Bus-cycle sequencer: machine cycles of T-states, wait insertion,
// opcode fetch with refresh, and non-maskable interrupt vectoring.
// Assumes memory answers synchronously and inputs are clock-synchronous.
`timescale 1ns/10ps
module bcs_sequencer #(
    parameter int          AUTO_WAITS = 0,
    parameter logic [6:0]  REFRESH_INIT = 7'h00
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Parallel bus
    output logic [15:0]      addr,
    output logic             addr_oe,
    input  wire logic [7:0]  data_in,
    output logic             memory_request_strobe_b,
    output logic             read_strobe_b,
    output logic             refresh_strobe_b,
    output logic             opcode_fetch_cycle_b,
    output logic             ctrl_oe,
    input  wire logic        wait_b,
    input  wire logic        nmi_b,
    input  wire logic        int_b,
    input  wire logic        int_enable,
    input  wire logic        bus_float_test_mode,
    // Core side
    input  wire logic        last_cycle,
    input  wire logic        data_read_req,
    input  wire logic [15:0] data_read_addr,
    input  wire logic        jump_valid,
    input  wire logic [15:0] jump_addr,
    output logic [7:0]       opcode,
    output logic             opcode_valid,
    output logic [7:0]       read_data,
    output logic             read_valid,
    output logic             nmi_taken,
    output logic             int_pending,
    output logic [15:0]      pc,
    // Serial channel event inputs and outputs
    input  wire logic        transmit_clock_in,
    input  wire logic        ser_ready_mode,
    input  wire logic        ser_tx_event,
    input  wire logic        ser_irq_ack,
    output logic             ser_wait_ready_b,
    output logic             ser_irq_b
);
    bcs_pkg::bcs_tstate_t t_q;
    bcs_pkg::bcs_tstate_t t_d;
    bcs_pkg::bcs_cycle_t  cyc_q;
    logic [15:0]          pc_q;
    logic [15:0]          addr_q;
    logic [6:0]           rfsh_q;
    logic [1:0]           auto_cnt_q;
    logic                 wait_smp_q;
    logic                 memory_request_strobe_fall_q;
    logic                 nmi_prev_q;
    logic                 nmi_latch_q;
    logic                 rfsh_memory_request_strobe_q;
    logic                 end_cycle;
    logic                 is_fetch;
    logic                 nmi_now;
    logic                 in_rfsh;
    logic                 read_end;

    // Decode helpers shared by sequencing and strobes
    assign is_fetch  = (cyc_q == bcs_pkg::BCS_CYC_FETCH) || (cyc_q == bcs_pkg::BCS_CYC_NMI);
    assign end_cycle = is_fetch ? (t_q == bcs_pkg::BCS_T4) : (t_q == bcs_pkg::BCS_T3);
    // Refresh window of fetch and acknowledge cycles
    assign in_rfsh   = is_fetch && (t_q == bcs_pkg::BCS_T3 || t_q == bcs_pkg::BCS_T4);
    assign read_end  = (t_q == bcs_pkg::BCS_T2 || t_q == bcs_pkg::BCS_TW) &&
                       (t_d == bcs_pkg::BCS_T3);
    // An edge seen in the deciding cycle itself counts as well
    assign nmi_now   = nmi_latch_q || (nmi_prev_q && !nmi_b);

    // Wait sampled on the falling clock edge inside T2 and waits
    always_ff @(negedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_smp_q <= 1'b1;
        end else if (t_q == bcs_pkg::BCS_T2 || t_q == bcs_pkg::BCS_TW) begin
            wait_smp_q <= wait_b;
        end
    end

    // Strobe asserted on the falling edge after the address goes out
    always_ff @(negedge clock or negedge rst_b) begin
        if (!rst_b) begin
            memory_request_strobe_fall_q <= 1'b0;
        end else begin
            memory_request_strobe_fall_q <= (t_q == bcs_pkg::BCS_T1) || (t_q == bcs_pkg::BCS_T2) ||
                           (t_q == bcs_pkg::BCS_TW) ||
                           (!is_fetch && t_q == bcs_pkg::BCS_T3 && !end_cycle);
        end
    end

    // Refresh strobe runs mid T3 to mid T4, half a state behind its address
    always_ff @(negedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rfsh_memory_request_strobe_q <= 1'b0;
        end else begin
            rfsh_memory_request_strobe_q <= is_fetch && t_q == bcs_pkg::BCS_T3;
        end
    end

    // T-state progression: T1, T2, waits, T3, then T4 for fetches
    always_comb begin
        t_d = t_q;
        case (t_q)
            bcs_pkg::BCS_T1: t_d = bcs_pkg::BCS_T2;
            // External wait and internal count both stretch the cycle
            bcs_pkg::BCS_T2, bcs_pkg::BCS_TW: begin
                if (!wait_smp_q || auto_cnt_q != 2'h0) begin
                    t_d = bcs_pkg::BCS_TW;
                end else begin
                    t_d = bcs_pkg::BCS_T3;
                end
            end
            bcs_pkg::BCS_T3: t_d = is_fetch ? bcs_pkg::BCS_T4 : bcs_pkg::BCS_T1;
            bcs_pkg::BCS_T4: t_d = bcs_pkg::BCS_T1;
            default:         t_d = bcs_pkg::BCS_T1;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            t_q <= bcs_pkg::BCS_T1;
        end else begin
            t_q <= t_d;
        end
    end

    // Automatic wait count, reloaded each first state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            auto_cnt_q <= 2'h0;
        end else if (t_q == bcs_pkg::BCS_T1) begin
            auto_cnt_q <= 2'(AUTO_WAITS);
        end else if (auto_cnt_q != 2'h0) begin
            auto_cnt_q <= auto_cnt_q - 2'h1;
        end
    end

    // NMI edge latched at the same sampling point as the maskable one
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            nmi_prev_q  <= 1'b1;
            nmi_latch_q <= 1'b0;
        end else begin
            nmi_prev_q <= nmi_b;
            // Set wins over the clear so a late edge is not lost
            if (nmi_prev_q && !nmi_b) begin
                nmi_latch_q <= 1'b1;
            end else if (end_cycle && last_cycle) begin
                nmi_latch_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_pending <= 1'b0;
        end else if (end_cycle && last_cycle) begin
            // No enable gates the non-maskable path; it also masks INT
            int_pending <= !int_b && int_enable && !nmi_now;
        end else if (t_q == bcs_pkg::BCS_T1) begin
            int_pending <= 1'b0;
        end
    end

    // Cycle type and address chosen at each cycle boundary
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cyc_q  <= bcs_pkg::BCS_CYC_FETCH;
            addr_q <= bcs_pkg::PC_RESET;
        end else if (end_cycle) begin
            if (cyc_q == bcs_pkg::BCS_CYC_NMI) begin
                // Ack cycle is followed straight by the fetch at the vector,
                // whatever the core asks for; the old pc is stale here
                cyc_q  <= bcs_pkg::BCS_CYC_FETCH;
                addr_q <= bcs_pkg::NMI_VECTOR;
            end else if (last_cycle && nmi_now) begin
                cyc_q  <= bcs_pkg::BCS_CYC_NMI;
                addr_q <= pc_q;
            end else if (last_cycle) begin
                cyc_q  <= bcs_pkg::BCS_CYC_FETCH;
                addr_q <= jump_valid ? jump_addr : pc_q;
            end else if (data_read_req) begin
                cyc_q  <= bcs_pkg::BCS_CYC_READ;
                addr_q <= data_read_addr;
            end else begin
                cyc_q  <= bcs_pkg::BCS_CYC_FETCH;
                addr_q <= pc_q;
            end
        end
    end

    // Program counter advances past fetched bytes; NMI restarts it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= bcs_pkg::PC_RESET;
        // Counter follows the restart so the vector fetch advances from it
        end else if (t_q == bcs_pkg::BCS_T4 && cyc_q == bcs_pkg::BCS_CYC_NMI) begin
            pc_q <= bcs_pkg::NMI_VECTOR;
        end else if (t_q == bcs_pkg::BCS_T1 && cyc_q == bcs_pkg::BCS_CYC_FETCH) begin
            pc_q <= addr_q + 16'h0001;
        end
    end

    // Refresh address counts once per fetch
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rfsh_q <= REFRESH_INIT;
        end else if (is_fetch && t_q == bcs_pkg::BCS_T4) begin
            rfsh_q <= rfsh_q + 7'h01;
        end
    end

    // Data captured at the end of the read window
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            opcode       <= 8'h00;
            opcode_valid <= 1'b0;
            read_data    <= 8'h00;
            read_valid   <= 1'b0;
            nmi_taken    <= 1'b0;
        end else begin
            opcode_valid <= 1'b0;
            read_valid   <= 1'b0;
            nmi_taken    <= 1'b0;
            if (read_end) begin
                case (cyc_q)
                    bcs_pkg::BCS_CYC_FETCH: begin
                        opcode       <= data_in;
                        opcode_valid <= 1'b1;
                    end
                    bcs_pkg::BCS_CYC_READ: begin
                        read_data  <= data_in;
                        read_valid <= 1'b1;
                    end
                    // Shaped like a fetch, but the byte goes nowhere
                    bcs_pkg::BCS_CYC_NMI: nmi_taken <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        addr = addr_q;
        if (in_rfsh) begin
            addr = {9'h000, rfsh_q};
        end
    end

    always_comb begin
        memory_request_strobe_b = ~memory_request_strobe_fall_q;
        // Read stays off through refresh so memory never drives then
        read_strobe_b    = ~(memory_request_strobe_fall_q && !in_rfsh);
        refresh_strobe_b = ~in_rfsh;
        if (in_rfsh) begin
            memory_request_strobe_b = ~rfsh_memory_request_strobe_q;
        end
        opcode_fetch_cycle_b = ~(is_fetch && t_q != bcs_pkg::BCS_T3
                                 && t_q != bcs_pkg::BCS_T4);
    end

    // Float mode releases the bus so an outside master sees the same timing
    assign addr_oe = ~bus_float_test_mode;
    assign ctrl_oe = ~bus_float_test_mode;
    assign pc      = pc_q;

    // Serial clock must be sampled, hence the rate limit
    bcs_ser_delay #(
        .DELAY (bcs_pkg::SER_DLY_CYC)
    ) u_ser_delay (
        .clock             (clock),
        .rst_b             (rst_b),
        .transmit_clock_in (transmit_clock_in),
        .ready_mode        (ser_ready_mode),
        .tx_event          (ser_tx_event),
        .wait_ready_b      (ser_wait_ready_b),
        .ser_irq_b         (ser_irq_b),
        .irq_ack           (ser_irq_ack)
    );

endmodule : bcs_sequencer

// ---- bcs_ser_delay.sv ----
// Serial event delay: turns a transmit-clock falling edge into a delayed
// ready-low and interrupt request. Transmit clock is sampled synchronously.
`timescale 1ns/10ps
module bcs_ser_delay #(
    parameter logic [3:0] DELAY = bcs_pkg::SER_DLY_CYC
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic transmit_clock_in,
    input  wire logic ready_mode,
    input  wire logic tx_event,
    output logic      wait_ready_b,
    output logic      ser_irq_b,
    input  wire logic irq_ack
);
    logic       txc_prev_q;
    logic [3:0] cnt_q;
    logic       run_q;
    logic       pend_q;
    logic       fall;

    // Edge of the transmit clock, one cycle of detection latency
    assign fall = txc_prev_q & ~transmit_clock_in;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txc_prev_q <= 1'b1;
        end else begin
            txc_prev_q <= transmit_clock_in;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= 4'h0;
            run_q  <= 1'b0;
            pend_q <= 1'b0;
        end else if (fall) begin
            cnt_q  <= 4'h1;
            run_q  <= 1'b1;
            pend_q <= tx_event;
        end else if (run_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == DELAY) begin
                run_q <= 1'b0;
            end
        end
    end

    // Total latency from the falling edge lands inside 5..9 periods
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_ready_b <= 1'b1;
        end else if (run_q && cnt_q == DELAY) begin
            wait_ready_b <= ~ready_mode;
        end else if (!transmit_clock_in && !run_q) begin
            wait_ready_b <= wait_ready_b;
        end else begin
            wait_ready_b <= 1'b1;
        end
    end

    // Request holds until acknowledged; a new one wins over the ack
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ser_irq_b <= 1'b1;
        end else if (run_q && cnt_q == DELAY && pend_q) begin
            ser_irq_b <= 1'b0;
        end else if (irq_ack) begin
            ser_irq_b <= 1'b1;
        end
    end

endmodule : bcs_ser_delay

// ---- tb.sv ----
// Self-checking bench for the bus-cycle sequencer and pattern memory.
// Assumes checker and memory model are compiled before this file.
`timescale 1ns/10ps
module tb;
    logic        clock = 1'b0, rst_b = 1'b0, nmi_b = 1'b1, int_b = 1'b1, int_enable = 1'b0;
    logic        bus_float_test_mode = 1'b0, last_cycle = 1'b0, data_read_req = 1'b0;
    logic        jump_valid = 1'b0, transmit_clock_in = 1'b1, ser_ready_mode = 1'b0;
    logic        ser_tx_event = 1'b0, ser_irq_ack = 1'b0, quiet = 1'b0, float_on = 1'b0;
    logic        rd_q = 1'b1, vec_q = 1'b0, nmi_q = 1'b1;
    logic [15:0] data_read_addr = 16'h0000, jump_addr = 16'h0000, cap_q = 16'h0000;
    logic [1:0]  wait_len = 2'h0;
    logic [31:0] seed = 32'h00006989;
    logic [15:0] addr, pc;
    logic [7:0]  data_in, opcode, read_data;
    logic        wait_b, addr_oe, ctrl_oe, memory_request_strobe_b, read_strobe_b;
    logic        refresh_strobe_b, opcode_fetch_cycle_b, opcode_valid, read_valid;
    logic        nmi_taken, ser_wait_ready_b, ser_irq_b, int_pending;
    int          n_mismatch = 0, cmp_count = 0;

    always #10 clock = ~clock;

    bcs_sequencer i_dut (.clock, .rst_b, .addr, .addr_oe, .data_in, .memory_request_strobe_b,
        .read_strobe_b, .refresh_strobe_b, .opcode_fetch_cycle_b, .ctrl_oe, .wait_b, .nmi_b,
        .int_b, .int_enable, .bus_float_test_mode, .last_cycle, .data_read_req,
        .data_read_addr, .jump_valid, .jump_addr, .opcode, .opcode_valid, .read_data,
        .read_valid, .nmi_taken, .int_pending, .pc, .transmit_clock_in, .ser_ready_mode,
        .ser_tx_event, .ser_irq_ack, .ser_wait_ready_b, .ser_irq_b);
    bcs_mem_model i_mem (.clock, .addr, .memory_request_strobe_b, .read_strobe_b, .wait_len,
        .data_in, .wait_b);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [15:0] exp_of(input logic [15:0] a);
        return {8'h00, a[7:0] ^ a[15:8] ^ 8'h5A};
    endfunction : exp_of

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // Bounded wait; sel 0 nmi_taken, 1 ready output, 2 serial interrupt
    task automatic wait_on(input int sel, input logic v, output int n);
        logic s;
        for (n = 1; n <= 200; n++) begin
            @(posedge clock);
            #1;
            s = (sel == 0) ? nmi_taken : (sel == 1) ? ser_wait_ready_b : ser_irq_b;
            if (s === v) return;
        end
        check("wait bound", 16'h0001, 16'h0000);
        close_out();
    endtask : wait_on

    // Random core-side traffic; reads requested only off the last cycle
    always @(posedge clock) begin
        seed = xs(seed);
        last_cycle <= seed[0];
        data_read_req <= seed[1] & ~seed[0];
        data_read_addr <= seed[31:16];
        jump_valid <= quiet ? 1'b0 : (seed[4:2] == 3'h0);
        jump_addr <= seed[23:8];
        int_b <= seed[5];
        int_enable <= seed[6];
        wait_len <= seed[8:7];
        bus_float_test_mode <= float_on & (seed[12:9] == 4'h0);
    end

    always @(posedge clock) begin
        rd_q <= read_strobe_b;
        nmi_q <= nmi_b;
        if (!nmi_q) check("nmi priority", {15'h0000, int_pending}, 16'h0000);
        if (rd_q && !read_strobe_b) begin
            cap_q <= addr;
            if (vec_q && !opcode_fetch_cycle_b) begin
                check("vector", addr, bcs_pkg::NMI_VECTOR);
                vec_q <= 1'b0;
            end
        end
        if (opcode_valid) check("opcode", {8'h00, opcode}, exp_of(cap_q));
        if (read_valid) check("read data", {8'h00, read_data}, exp_of(cap_q));
        if (nmi_taken) vec_q <= 1'b1;
    end

    initial begin
        int n;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        float_on <= 1'b1;
        repeat (3000) @(posedge clock);
        float_on <= 1'b0;
        quiet <= 1'b1;
        $display("Test random bus done");
        // Maskable interrupt random meanwhile: the NMI must win every time
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            nmi_b <= 1'b0;
            wait_on(0, 1'b1, n);
            @(posedge clock);
            nmi_b <= 1'b1;
            repeat (30) @(posedge clock);
            check("vector fetched", {15'h0000, vec_q}, 16'h0000);
        end
        $display("Test nmi done");
        ser_ready_mode <= 1'b1;
        ser_tx_event <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            transmit_clock_in <= 1'b1;
            repeat (6) @(posedge clock);
            transmit_clock_in <= 1'b0;
            wait_on(1 + k % 2, 1'b0, n);
            check("serial delay", 16'(n >= 5 && n <= 9), 16'h0001);
            @(posedge clock);
            ser_irq_ack <= 1'b1;
            @(posedge clock);
            ser_irq_ack <= 1'b0;
            wait_on(2, 1'b1, n);
        end
        $display("Test serial done");
        close_out();
    end
endmodule : tb
